//--- rtl/rplc_host.sv
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module rplc_host #(
    parameter int PWRUP_WAIT_CYC = rplc_pkg::PWRUP_WAIT_CYC
) (
    input  wire logic                    core_clk,
    input  wire logic                    resetn,
    input  wire logic                    clk_en,
    input  wire rplc_pkg::rplc_apb_req_t apb_req,
    output var  logic [31:0]             prdata,
    output var  logic                    pready,
    output var  logic                    pslverr,
    output var  rplc_pkg::rplc_spi_t     spi,
    input  wire logic                    miso,
    input  wire logic                    device_int_low,
    output var  logic                    radio_activate
);
    rplc_pkg::rplc_state_t state;
    logic [7:0]  mem [rplc_pkg::BUF_DEPTH];
    logic        miso_m;
    logic        miso_s;
    logic        int_m;
    logic        int_s;
    logic        int_seen;
    logic [6:0]  xfer_len;
    logic        ce_hold;
    logic        go_xfer;
    logic        go_pulse;
    logic        go_wait;
    logic        pulse_pend;
    logic [11:0] ce_cnt;
    logic [3:0]  half_cnt;
    logic [2:0]  bit_idx;
    logic [5:0]  byte_idx;
    logic [7:0]  sh;
    logic        last_bit;
    logic [18:0] wait_cnt;
    logic [7:0]  dev_status;
    logic [9:0]  rise_cnt;
    logic        acc;
    logic        busy;
    logic        is_ctrl;
    logic        is_stat;
    logic        is_data;
    logic [5:0]  idx;
    logic        tick;
    logic        byte_done;
    logic        min_met;
    logic        len_ok;
    logic [6:0]  wr_len;

    assign acc       = apb_req.psel & apb_req.penable & ~pready;
    assign busy      = state != rplc_pkg::ST_IDLE;
    assign is_ctrl   = apb_req.paddr == rplc_pkg::OFS_CTRL;
    assign is_stat   = apb_req.paddr == rplc_pkg::OFS_STATUS;
    assign is_data   = apb_req.paddr[11:8] == rplc_pkg::DATA_PAGE && apb_req.paddr[1:0] == 2'h0;
    assign idx       = apb_req.paddr[7:2];
    assign tick      = half_cnt == 4'(rplc_pkg::SCK_HALF - 1);
    assign byte_done = state == rplc_pkg::ST_XFER && tick && spi.sck && bit_idx == 3'h7;
    assign min_met   = radio_activate && ce_cnt >= 12'(rplc_pkg::CE_MIN_CYC - 1);
    assign wr_len    = apb_req.pwdata[rplc_pkg::CTRL_LEN_LSB +: rplc_pkg::LEN_W];
    assign len_ok    = wr_len != 7'h00 && wr_len <= rplc_pkg::LEN_MAX;

    // pin synchronisers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            miso_m <= 1'b0;
            miso_s <= 1'b0;
            int_m  <= 1'b1;
            int_s  <= 1'b1;
        end else if (clk_en) begin
            miso_m <= miso;
            miso_s <= miso_m;
            int_m  <= device_int_low;
            int_s  <= int_m;
        end
    end

    // device interrupt level, cleared only by the device itself
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            int_seen <= 1'b0;
        end else if (clk_en) begin
            int_seen <= ~int_s;
        end
    end

    // apb slave: one wait state, then pready for one cycle
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h0;
            xfer_len <= 7'h01;
            ce_hold  <= 1'b0;
            go_xfer  <= 1'b0;
            go_pulse <= 1'b0;
            go_wait  <= 1'b0;
        end else if (clk_en) begin
            pready   <= acc;
            pslverr  <= 1'b0;
            go_xfer  <= 1'b0;
            go_pulse <= 1'b0;
            go_wait  <= 1'b0;
            if (acc) begin
                prdata <= 32'h0;
                if (is_ctrl) begin
                    prdata[rplc_pkg::CTRL_CE_HOLD] <= ce_hold;
                    prdata[rplc_pkg::CTRL_LEN_LSB +: rplc_pkg::LEN_W] <= xfer_len;
                    if (apb_req.pwrite) begin
                        ce_hold  <= apb_req.pwdata[rplc_pkg::CTRL_CE_HOLD];
                        go_pulse <= apb_req.pwdata[rplc_pkg::CTRL_CE_PULSE];
                        // a busy engine refuses new go and wait commands; ce_hold and the activate pulse are still taken
                        if (busy) begin
                            pslverr <= apb_req.pwdata[rplc_pkg::CTRL_GO] | apb_req.pwdata[rplc_pkg::CTRL_WAIT];
                        end else if (apb_req.pwdata[rplc_pkg::CTRL_GO]) begin
                            pslverr <= ~len_ok;
                            if (len_ok) begin
                                xfer_len <= wr_len;
                                go_xfer  <= 1'b1;
                            end
                        end else begin
                            go_wait <= apb_req.pwdata[rplc_pkg::CTRL_WAIT];
                            if (len_ok) begin
                                xfer_len <= wr_len;
                            end
                        end
                    end
                end else if (is_stat) begin
                    pslverr <= apb_req.pwrite;
                    prdata[rplc_pkg::STAT_BUSY] <= busy;
                    prdata[rplc_pkg::STAT_INT]  <= int_seen;
                    prdata[rplc_pkg::STAT_CE]   <= radio_activate;
                    prdata[rplc_pkg::STAT_DEV_LSB +: 8] <= dev_status;
                end else if (is_data) begin
                    pslverr <= apb_req.pwrite & busy;
                    prdata[7:0] <= mem[idx];
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // shared byte buffer: software fills it, the shifter overwrites with returned bytes
    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            if (acc && apb_req.pwrite && is_data && !busy) begin
                mem[idx] <= apb_req.pwdata[7:0];
            end else if (byte_done) begin
                mem[byte_idx] <= {sh[6:0], miso_s};
            end
        end
    end

    // first returned byte is the device status
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dev_status <= 8'h00;
        end else if (clk_en && byte_done && byte_idx == 6'h00) begin
            dev_status <= {sh[6:0], miso_s};
        end
    end

    // serial engine, mode 0; select held low across all bytes of one command
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state    <= rplc_pkg::ST_IDLE;
            spi      <= '{sck: 1'b0, mosi: 1'b0, serial_select_low: 1'b1};
            half_cnt <= 4'h0;
            bit_idx  <= 3'h0;
            byte_idx <= 6'h00;
            sh       <= 8'h00;
            last_bit <= 1'b0;
            wait_cnt <= 19'h00000;
        end else if (clk_en) begin
            unique case (state)
                rplc_pkg::ST_IDLE: begin
                    half_cnt <= 4'h0;
                    bit_idx  <= 3'h0;
                    byte_idx <= 6'h00;
                    last_bit <= 1'b0;
                    wait_cnt <= 19'h00000;
                    if (go_xfer) begin
                        state                 <= rplc_pkg::ST_XFER;
                        spi.serial_select_low <= 1'b0;
                        spi.mosi              <= mem[0][7];
                        sh                    <= mem[0];
                    end else if (go_wait) begin
                        state <= rplc_pkg::ST_WAIT;
                    end
                end
                rplc_pkg::ST_XFER: begin
                    half_cnt <= tick ? 4'h0 : 4'(half_cnt + 4'h1);
                    if (tick && !spi.sck) begin
                        if (last_bit) begin
                            spi.serial_select_low <= 1'b1;
                            spi.mosi              <= 1'b0;
                            state                 <= rplc_pkg::ST_IDLE;
                        end else begin
                            spi.sck <= 1'b1;
                        end
                    end else if (tick) begin
                        // miso sampled late in the high phase to absorb the synchroniser delay
                        spi.sck <= 1'b0;
                        sh      <= {sh[6:0], miso_s};
                        bit_idx <= 3'(bit_idx + 3'h1);
                        if (bit_idx != 3'h7) begin
                            spi.mosi <= sh[6];
                        end else if (byte_idx == 6'(xfer_len - 7'h01)) begin
                            last_bit <= 1'b1;
                        end else begin
                            byte_idx <= 6'(byte_idx + 6'h01);
                            sh       <= mem[6'(byte_idx + 6'h01)];
                            spi.mosi <= mem[6'(byte_idx + 6'h01)][7];
                        end
                    end
                end
                rplc_pkg::ST_WAIT: begin
                    wait_cnt <= 19'(wait_cnt + 19'h00001);
                    if (wait_cnt == 19'(PWRUP_WAIT_CYC - 1)) begin
                        state <= rplc_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= rplc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // radio_activate: level or pulse, never shorter than the minimum width
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            radio_activate <= 1'b0;
            pulse_pend     <= 1'b0;
            ce_cnt         <= 12'h000;
        end else if (clk_en) begin
            pulse_pend     <= go_pulse | (pulse_pend & ~min_met);
            radio_activate <= ce_hold | go_pulse | (pulse_pend & ~min_met) | (radio_activate & ~min_met);
            if (!radio_activate) begin
                ce_cnt <= 12'h000;
            end else if (ce_cnt != 12'hFFF) begin
                ce_cnt <= 12'(ce_cnt + 12'h001);
            end
        end
    end

    // helper: clock rises seen during one select window
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rise_cnt <= 10'h000;
        end else if (clk_en) begin
            if (state == rplc_pkg::ST_IDLE && go_xfer) begin
                rise_cnt <= 10'h000;
            end else if (state == rplc_pkg::ST_XFER && tick && !spi.sck && !last_bit) begin
                rise_cnt <= 10'(rise_cnt + 10'h001);
            end
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn || !clk_en);

    sequence s_select_fall;
        $fell(spi.serial_select_low);
    endsequence

    sequence s_select_rise;
        $rose(spi.serial_select_low);
    endsequence

    property p_select_hold;
        s_select_fall |-> !spi.serial_select_low [*8];
    endproperty
    a_select_hold: assert property (p_select_hold) else $error("select released too early");

    property p_bit_count;
        s_select_rise |-> rise_cnt == {xfer_len, 3'h0};
    endproperty
    a_bit_count: assert property (p_bit_count) else $error("clock count differs from byte count");

    property p_idle_pins;
        state == rplc_pkg::ST_IDLE && !go_xfer |=> spi.serial_select_low && !spi.sck;
    endproperty
    a_idle_pins: assert property (p_idle_pins) else $error("serial pins active while idle");

    property p_sck_high;
        $rose(spi.sck) |-> spi.sck [*8];
    endproperty
    a_sck_high: assert property (p_sck_high) else $error("serial clock high phase too short");

    property p_ce_min;
        $fell(radio_activate) |-> ce_cnt >= 12'(rplc_pkg::CE_MIN_CYC);
    endproperty
    a_ce_min: assert property (p_ce_min) else $error("activate pulse shorter than minimum");

    property p_ce_pulse_start;
        go_pulse |=> radio_activate;
    endproperty
    a_ce_pulse_start: assert property (p_ce_pulse_start) else $error("activate pulse not started");

    property p_int_follow;
        $fell(device_int_low) ##1 !device_int_low [*3] |-> int_seen;
    endproperty
    a_int_follow: assert property (p_int_follow) else $error("device interrupt not reported");

    property p_apb_answer;
        acc |=> pready ##1 !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb answer not one cycle");

    property p_wait_busy;
        $rose(state == rplc_pkg::ST_WAIT) |-> busy [*8];
    endproperty
    a_wait_busy: assert property (p_wait_busy) else $error("power-up wait ended early");

endmodule : rplc_host
`default_nettype wire

//--- rtl/rplc_pkg.sv
`default_nettype none
package rplc_pkg;
    // timing
    localparam int CLK_NS         = 5;
    localparam int SCK_PERIOD_NS  = 125;
    localparam int SCK_HALF       = (SCK_PERIOD_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
    localparam int CE_MIN_NS      = 10000;
    localparam int CE_MIN_CYC     = (CE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int PWRUP_WAIT_NS  = 1500000;
    localparam int PWRUP_WAIT_CYC = (PWRUP_WAIT_NS + CLK_NS - 1) / CLK_NS;

    // register map
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [3:0]  DATA_PAGE  = 4'h1;
    localparam int          BUF_DEPTH  = 64;

    // control fields
    localparam int CTRL_GO       = 0;
    localparam int CTRL_CE_HOLD  = 1;
    localparam int CTRL_CE_PULSE = 2;
    localparam int CTRL_WAIT     = 3;
    localparam int CTRL_LEN_LSB  = 8;
    localparam int LEN_W         = 7;
    localparam logic [6:0] LEN_MAX = 7'h40;

    // status fields
    localparam int STAT_BUSY    = 0;
    localparam int STAT_INT     = 1;
    localparam int STAT_CE      = 2;
    localparam int STAT_DEV_LSB = 8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_XFER = 3'b010,
        ST_WAIT = 3'b100
    } rplc_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } rplc_apb_req_t;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic serial_select_low;
    } rplc_spi_t;
endpackage : rplc_pkg
`default_nettype wire

//--- test/rplc_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module rplc_dev_model (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       serial_select_low,
    input  wire logic       radio_activate,
    output var  logic       miso,
    output var  logic       device_int_low,
    output var  logic [7:0] nbytes,
    output var  logic       frame_err
);
    logic [7:0] status = 8'h0E;
    logic [7:0] cmd    = 8'h00;
    logic [7:0] sh_in  = 8'h00;
    logic [7:0] sh_out = 8'h00;
    int         bits   = 0;
    realtime    t_rise = 0.0;
    initial begin
        miso      = 1'b0;
        nbytes    = 8'h00;
        frame_err = 1'b0;
    end
    always_comb device_int_low = ~(status[5] | status[4]);
    always @(negedge serial_select_low) begin
        bits   = 0;
        nbytes = 8'h00;
        sh_out = status;
        miso   = status[7];
    end
    always @(posedge sck) begin
        if (serial_select_low == 1'b0) begin
            sh_in = {sh_in[6:0], mosi};
            bits++;
            if (bits % 8 == 0) begin
                if (bits == 8) cmd = sh_in;
                else if (cmd[7]) status = status & ~sh_in;
                nbytes = 8'(bits / 8);
                sh_out = ~sh_in;
            end else begin
                sh_out = {sh_out[6:0], 1'b0};
            end
        end
    end
    always @(negedge sck) miso = sh_out[7];
    // released line shows the inverse so a stale sample cannot pass
    always @(posedge serial_select_low) begin
        if (bits % 8 != 0) frame_err = 1'b1;
        miso = ~miso;
    end
    always @(posedge radio_activate) t_rise = $realtime;
    // short pulses are ignored, as a real start needs the minimum width
    always @(negedge radio_activate) begin
        if ($realtime - t_rise >= 10000.0) status[5] = 1'b1;
    end
endmodule : rplc_dev_model
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic        wr;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] q;
        logic        err;
    } rplc_row_t;
    logic                    core_clk = 1'b0;
    logic                    resetn   = 1'b0;
    logic                    clk_en   = 1'b1;
    rplc_pkg::rplc_apb_req_t req      = '0;
    rplc_pkg::rplc_spi_t     spi;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic                    miso;
    logic                    device_int_low;
    logic                    radio_activate;
    logic                    frame_err;
    logic [7:0]              nbytes;
    logic [31:0]             rd;
    logic                    err;
    int                      miscompares  = 0;
    int                      total_checks = 0;
    int                      cycles       = 0;
    int                      w;
    rplc_row_t rows [6] = '{
        '{1'b1, 12'h004, 32'h0000_0000, 32'h0, 1'b1},
        '{1'b0, 12'h008, 32'h0000_0000, 32'h0, 1'b1},
        '{1'b0, 12'h200, 32'h0000_0000, 32'h0, 1'b1},
        '{1'b1, 12'h000, 32'h0000_0001, 32'h0, 1'b1},
        '{1'b1, 12'h000, 32'h0000_4101, 32'h0, 1'b1},
        '{1'b1, 12'h1FC, 32'h0000_005A, 32'h0, 1'b0}
    };
    rplc_host #(.PWRUP_WAIT_CYC(50)) dut (
        .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .apb_req(req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .spi(spi),
        .miso(miso), .device_int_low(device_int_low), .radio_activate(radio_activate)
    );
    rplc_dev_model partner (
        .sck(spi.sck), .mosi(spi.mosi), .serial_select_low(spi.serial_select_low),
        .radio_activate(radio_activate), .miso(miso), .device_int_low(device_int_low),
        .nbytes(nbytes), .frame_err(frame_err)
    );
    initial forever #2.5 core_clk = ~core_clk;
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    // whole run needs well under this many cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            $display("wrong value at %0t: run timed out", $time);
            give_verdict();
        end
    end
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk_word
    task automatic chk_bit(input logic g, input logic e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: flag %b expected %b", $time, g, e);
        end
    endtask : chk_bit
    // waits for pready as long as it takes; only the run timeout ends a hang
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge core_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        req <= '0;
    endtask : apb
    task automatic wait_idle;
        do begin
            apb(1'b0, 12'h004, 32'h0);
        end while (rd[0] !== 1'b0);
        chk_bit(rd[0], 1'b0);
    endtask : wait_idle
    task automatic send3(input logic [23:0] b, input logic [6:0] len);
        for (int i = 0; i < 3; i++) apb(1'b1, 12'h100 + 12'(4 * i), {24'h0, b[23 - 8 * i -: 8]});
        apb(1'b1, 12'h000, {17'h0, len, 8'h01});
        apb(1'b1, 12'h000, {17'h0, len, 8'h01});
        chk_bit(err, 1'b1);
        apb(1'b1, 12'h100, 32'h0000_0055);
        chk_bit(err, 1'b1);
        wait_idle();
        chk_word(32'(nbytes), 32'(len));
        chk_bit(frame_err, 1'b0);
    endtask : send3
    initial begin
        repeat (12) @(posedge core_clk);
        chk_word({29'h0, spi.serial_select_low, spi.sck, radio_activate}, 32'h4);
        chk_bit(pready, 1'b0);
        resetn <= 1'b1;
        $display("test reset done");
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            chk_bit(err, rows[i].err);
            if (!rows[i].wr) chk_word(rd, rows[i].q);
        end
        apb(1'b0, 12'h1FC, 32'h0);
        chk_word(rd, 32'h0000_005A);
        $display("test register rows done");
        send3(24'h113CC3, 7'h03);
        chk_word(rd & 32'h0000_FF07, 32'h0000_0E00);
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 12'h100 + 12'(4 * i), 32'h0);
            chk_word(rd, (i == 0) ? 32'h0E : (i == 1) ? 32'hEE : 32'hC3);
        end
        $display("test transfer done");
        apb(1'b1, 12'h000, 32'h0000_0004);
        w = 0;
        while (radio_activate !== 1'b1 && w < 10) begin
            @(posedge core_clk);
            w++;
        end
        w = 0;
        while (radio_activate === 1'b1 && w < 3000) begin
            @(posedge core_clk);
            w++;
        end
        chk_bit(w >= 2000 && w < 3000, 1'b1);
        repeat (4) @(posedge core_clk);
        apb(1'b0, 12'h004, 32'h0);
        chk_word(rd & 32'h2, 32'h2);
        $display("test activate pulse done");
        send3(24'h802000, 7'h02);
        chk_word(rd & 32'h0000_FF02, 32'h0000_2E00);
        $display("test flag clear done");
        apb(1'b1, 12'h000, 32'h0000_0008);
        apb(1'b0, 12'h004, 32'h0);
        chk_bit(rd[0], 1'b1);
        apb(1'b1, 12'h000, 32'h0000_0101);
        chk_bit(err, 1'b1);
        wait_idle();
        $display("test power wait done");
        apb(1'b1, 12'h000, 32'h0000_0002);
        repeat (2100) @(posedge core_clk);
        chk_bit(radio_activate, 1'b1);
        apb(1'b0, 12'h004, 32'h0);
        chk_word(rd & 32'h4, 32'h4);
        apb(1'b1, 12'h000, 32'h0);
        w = 0;
        while (radio_activate !== 1'b0 && w < 20) begin
            @(posedge core_clk);
            w++;
        end
        chk_bit(radio_activate, 1'b0);
        $display("test activate hold done");
        // a frozen engine must not count its power-up wait down
        apb(1'b1, 12'h000, 32'h0000_0008);
        clk_en <= 1'b0;
        repeat (100) @(posedge core_clk);
        clk_en <= 1'b1;
        apb(1'b0, 12'h004, 32'h0);
        chk_bit(rd[0], 1'b1);
        wait_idle();
        $display("test clock enable done");
        apb(1'b1, 12'h000, 32'h0000_0002);
        repeat (5) @(posedge core_clk);
        resetn <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk_word({29'h0, spi.serial_select_low, spi.sck, radio_activate}, 32'h4);
        chk_bit(pready, 1'b0);
        resetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk_word(rd, 32'h0000_0100);
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
